// *** vtc_classifier.sv ***
// VLAN classifier and egress tag rewriter for one frame stream.
// Assumes frames arrive as bytes with their frame check sequence, and that
// the forwarding logic names the ingress and egress port with each frame.
`include "vtc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: A frame is tagged only when bytes 12 and 13 equal 0x8100.
// RULE2: Tag control holds priority, canonical flag, then VLAN id, from top.
// RULE3: Insert tag after source address, before length/type; four bytes.
// RULE4: Recompute frame check sequence whenever a tag is added or removed.
// RULE5: Untagged frames take the receiving port's default VLAN id.
// RULE6: Tagged frames take the VLAN id from their tag.
// RULE7: Drop frames whose VLAN does not include the egress port.
// RULE8: After reset all ports untagged members of VLAN 1, default id 1.
// RULE9: Ports joining a new VLAN leave the default VLAN.
// RULE10: The VLAN table holds up to 255 entries.
// RULE11: One default id per port, any number of memberships.
// RULE12: A port may belong to several VLANs at once.
// RULE13: Flooded frames reach only members of their VLAN.
// RULE14: Frames never cross from one VLAN to another.
// RULE15: Untagged egress ports strip the tag.
// RULE16: Tagged egress ports carry the VLAN in a tag.
// RULE17: Tagged in/out unchanged, untagged in/tagged out gets a tag.
// RULE18: Per-port egress tag bit and per-VLAN port bitmap are writable.
// RULE19: Inserted tags use configured priority, zero canonical flag.
module vtc_classifier #(
	parameter int PORTS = 10,
	parameter int VLANS = 255, // RULE10
	parameter int PW = $clog2(PORTS)
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port.
	input wire logic [9:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Ingress byte stream.
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	input wire logic in_last_i,
	input wire logic [PW-1:0] in_port_i,
	input wire logic [PW-1:0] in_egress_port_i,
	output logic in_ready_o,
	// Egress byte stream.
	output logic out_valid_o,
	output logic [7:0] out_data_o,
	output logic out_last_o,
	output vtc_pkg::vtc_vlan_id_t out_vlan_id_o,
	input wire logic out_ready_i
);
	import vtc_pkg::*;

	// Configuration state.
	vtc_vlan_id_t dflt_vlan_q [PORTS];
	logic [2:0] prio_q [PORTS];
	logic [PORTS-1:0] etag_q;
	logic ent_valid_q [VLANS];
	vtc_vlan_id_t ent_vlan_q [VLANS];
	logic [PORTS-1:0] ent_mem_q [VLANS];
	logic [15:0] pass_q;
	logic [15:0] drop_q;
	logic [31:0] rdata_q;

	// Frame state.
	vtc_state_t st_q, st_d;
	logic [4:0] rd_q, rd_d;
	logic [7:0] hdr_q [20];
	logic [PW-1:0] inp_q, eg_q;
	logic tagged_q, ins_q, strip_q;
	vtc_vlan_id_t vlan_id_q;
	logic [15:0] tci_q;
	logic in_ready_q, ready_d;
	logic out_valid_q, out_valid_d, out_last_q;
	logic [7:0] out_data_q;

	// Combinational helpers.
	logic adv, take, emit, olast, is_tag, member;
	logic [7:0] obyte;
	vtc_vlan_id_t cls_vlan;
	logic [VLANS-1:0] hit;
	logic [PW-1:0] wport;
	logic [7:0] went;

	vtc_crc_if crc_if ();

	vtc_crc u_crc (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.crc_if(crc_if)
	);

	assign wport = reg_addr_i[PW-1:0];
	assign went = reg_addr_i[7:0];

	// Configuration writes. Entry 0 is the default VLAN and is the only
	// one that is populated at reset.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			etag_q <= '0; // RULE8
			for (int p = 0; p < PORTS; p++) begin
				dflt_vlan_q[p] <= `VTC_DEF_VLAN; // RULE8
				prio_q[p] <= `VTC_DEF_PRIO;
			end
			for (int j = 0; j < VLANS; j++) begin
				ent_valid_q[j] <= (j == 0);
				ent_vlan_q[j] <= (j == 0) ? `VTC_DEF_VLAN : 12'h000;
				ent_mem_q[j] <= (j == 0) ? '1 : '0; // RULE8
			end
		end else if (reg_wr_i) begin
			if (reg_addr_i[9:4] == 6'h00 && 32'(reg_addr_i[3:0]) < PORTS) begin
				dflt_vlan_q[wport] <= reg_wdata_i[11:0]; // RULE11
				prio_q[wport] <= reg_wdata_i[14:12]; // RULE19
			end
			if (reg_addr_i == `VTC_REG_ETAG) begin
				etag_q <= reg_wdata_i[PORTS-1:0]; // RULE18
			end
			if (reg_addr_i[9:8] == 2'h1 && 32'(went) < VLANS) begin
				ent_valid_q[went] <= reg_wdata_i[`VTC_ENT_VALID_BIT];
				ent_vlan_q[went] <= reg_wdata_i[11:0];
				ent_mem_q[went] <= reg_wdata_i[`VTC_FIELD_LSB +: PORTS]; // RULE18
				if (went != 8'h00 && reg_wdata_i[`VTC_ENT_VALID_BIT]) begin
					ent_mem_q[0] <= ent_mem_q[0] &
						~reg_wdata_i[`VTC_FIELD_LSB +: PORTS]; // RULE9
				end
			end
		end
	end

	// Register reads answer one cycle later; unmapped words read zero.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= 32'h00000000;
			if (reg_rd_i) begin
				if (reg_addr_i[9:4] == 6'h00 && 32'(reg_addr_i[3:0]) < PORTS) begin
					rdata_q <= {17'h00000, prio_q[wport], dflt_vlan_q[wport]};
				end else if (reg_addr_i == `VTC_REG_ETAG) begin
					rdata_q <= 32'(etag_q);
				end else if (reg_addr_i == `VTC_REG_PASS) begin
					rdata_q <= {16'h0000, pass_q};
				end else if (reg_addr_i == `VTC_REG_DROP) begin
					rdata_q <= {16'h0000, drop_q};
				end else if (reg_addr_i[9:8] == 2'h1 && 32'(went) < VLANS) begin
					rdata_q <= {ent_valid_q[went], {(19 - PORTS){1'b0}},
						ent_mem_q[went], ent_vlan_q[went]};
				end
			end
		end
	end

	// Classification: the tag's id if present, else the port default.
	assign is_tag = {hdr_q[12], hdr_q[13]} == `VTC_TPID; // RULE1
	assign cls_vlan = is_tag ? {hdr_q[14][3:0], hdr_q[15]} // RULE2 RULE6
		: dflt_vlan_q[inp_q]; // RULE5

	// Every table entry is searched at once, so a port listed in several
	// entries is a member of each of them.
	for (genvar j = 0; j < VLANS; j++) begin : g_ent
		assign hit[j] = ent_valid_q[j] && ent_vlan_q[j] == cls_vlan &&
			ent_mem_q[j][eg_q]; // RULE12
	end

	// The egress check uses the same id that classified the frame, so a
	// frame can only leave on a member port of its own VLAN.
	assign member = (|hit) && 32'(eg_q) < PORTS; // RULE7 RULE13 RULE14

	// Sequencing of capture, rewrite and checksum append.
	always_comb begin
		adv = !out_valid_q || out_ready_i;
		take = in_valid_i && in_ready_q;
		emit = 1'b0;
		olast = 1'b0;
		obyte = hdr_q[rd_q];
		st_d = st_q;
		rd_d = rd_q;
		unique case (st_q)
			ST_HDR: begin
				if (take) begin
					rd_d = rd_q + 5'd1;
					if (in_last_i) begin
						rd_d = 5'd0;
					end else if (rd_q == `VTC_HDR_LEN - 5'd1) begin
						st_d = ST_DEC;
					end
				end
			end
			ST_DEC: begin
				rd_d = 5'd0;
				st_d = member ? ST_MAC : ST_DROP; // RULE7
			end
			ST_MAC: begin
				if (adv) begin
					emit = 1'b1;
					rd_d = rd_q + 5'd1;
					if (rd_q == `VTC_MAC_END) begin
						if (ins_q) begin
							st_d = ST_TAG; // RULE3 RULE16
							rd_d = 5'd0;
						end else if (strip_q) begin
							st_d = ST_STRM; // RULE15
						end else begin
							st_d = ST_BODY; // RULE17
						end
					end
				end
			end
			ST_TAG: begin
				obyte = rd_q[1] ? (rd_q[0] ? tci_q[7:0] : tci_q[15:8])
					: (rd_q[0] ? 8'(`VTC_TPID) : 8'(`VTC_TPID >> 8)); // RULE3
				if (adv) begin
					emit = 1'b1;
					rd_d = rd_q + 5'd1;
					if (rd_q == `VTC_TAG_END) begin
						st_d = ST_BODY;
						rd_d = `VTC_TYPE_POS;
					end
				end
			end
			ST_BODY: begin
				if (adv) begin
					emit = 1'b1;
					rd_d = rd_q + 5'd1;
					if (rd_q == `VTC_BODY_END) begin
						st_d = ST_STRM;
					end
				end
			end
			ST_STRM: begin
				obyte = hdr_q[16];
				if (take) begin
					emit = 1'b1;
					if (in_last_i) begin
						st_d = ST_FCS; // RULE4
						rd_d = 5'd0;
					end
				end
			end
			ST_FCS: begin
				obyte = ~crc_if.crc[{rd_q[1:0], 3'b000} +: 8]; // RULE4
				olast = rd_q == `VTC_TAG_END;
				if (adv) begin
					emit = 1'b1;
					rd_d = rd_q + 5'd1;
					if (olast) begin
						st_d = ST_HDR;
						rd_d = 5'd0;
					end
				end
			end
			ST_DROP: begin
				if (take && in_last_i) begin
					st_d = ST_HDR;
				end
			end
		endcase
		out_valid_d = emit || (out_valid_q && !out_ready_i);
		// Streaming only takes a byte when the output stage is free, which
		// keeps in_ready registered at the cost of half rate in the body.
		ready_d = st_d == ST_HDR || st_d == ST_DROP ||
			(st_d == ST_STRM && !out_valid_d);
	end

	assign crc_if.clr = st_q == ST_DEC;
	assign crc_if.en = emit && st_q != ST_FCS; // RULE4
	assign crc_if.data = obyte;

	// Sequencer and handshake registers.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q <= ST_HDR;
			rd_q <= 5'd0;
			in_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
			out_last_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rd_q <= rd_d;
			in_ready_q <= ready_d;
			out_valid_q <= out_valid_d;
			if (emit) begin
				out_data_q <= obyte;
				out_last_q <= olast;
			end
		end
	end

	// Header capture; the last four bytes double as the hold-back line
	// that keeps the old check sequence from reaching the output.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 20; i++) begin
				hdr_q[i] <= 8'h00;
			end
			inp_q <= '0;
			eg_q <= '0;
		end else if (take && st_q == ST_HDR) begin
			hdr_q[rd_q] <= in_data_i;
			if (rd_q == 5'd0) begin
				inp_q <= in_port_i;
				eg_q <= in_egress_port_i;
			end
		end else if (take && st_q == ST_STRM) begin
			for (int i = 16; i < 19; i++) begin
				hdr_q[i] <= hdr_q[i + 1];
			end
			hdr_q[19] <= in_data_i;
		end
	end

	// Per-frame decision and counters.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tagged_q <= 1'b0;
			ins_q <= 1'b0;
			strip_q <= 1'b0;
			vlan_id_q <= `VTC_DEF_VLAN;
			tci_q <= 16'h0000;
			pass_q <= 16'h0000;
			drop_q <= 16'h0000;
		end else if (st_q == ST_DEC) begin
			tagged_q <= is_tag;
			vlan_id_q <= cls_vlan;
			ins_q <= !is_tag && etag_q[eg_q]; // RULE16 RULE17
			strip_q <= is_tag && !etag_q[eg_q]; // RULE15 RULE17
			tci_q <= {prio_q[inp_q], `VTC_CANON_INS, cls_vlan}; // RULE19
			if (member) begin
				pass_q <= pass_q + 16'h0001;
			end else begin
				drop_q <= drop_q + 16'h0001;
			end
		end
	end

	assign reg_rdata_o = rdata_q;
	assign in_ready_o = in_ready_q;
	assign out_valid_o = out_valid_q;
	assign out_data_o = out_data_q;
	assign out_last_o = out_last_q;
	assign out_vlan_id_o = vlan_id_q;

	// Checks on the decision and the rewrite.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	tpid_detect_a: assert property (st_q == ST_DEC |=> // RULE1
		tagged_q == ($past({hdr_q[12], hdr_q[13]}) == 16'h8100))
		else $error("tag detection mismatch");
	tci_split_a: assert property (st_q == ST_DEC && is_tag |=> // RULE2
		vlan_id_q == $past({hdr_q[14][3:0], hdr_q[15]}))
		else $error("tagged id not taken from tag");
	dflt_class_a: assert property (st_q == ST_DEC && !is_tag |=> // RULE5
		vlan_id_q == $past(dflt_vlan_q[inp_q]))
		else $error("untagged frame not given port default id");
	tag_insert_a: assert property (st_q == ST_TAG && rd_q == 5'd0 && emit // RULE3
		|=> out_data_o == 8'h81 && out_valid_o)
		else $error("inserted tag does not start with 81");
	member_drop_a: assert property (st_q == ST_DEC && !member // RULE7
		|=> st_q == ST_DROP ##1 !out_valid_o [*3])
		else $error("non-member frame not dropped");
	fcs_append_a: assert property (st_q == ST_STRM && take && in_last_i // RULE4
		|=> st_q == ST_FCS ##[1:40] out_last_o && out_valid_o)
		else $error("check sequence not appended");
	reset_dflt_a: assert property ($fell(sys_rst_i) |-> // RULE8
		ent_vlan_q[0] == 12'h001 && ent_mem_q[0] == '1 && etag_q == '0)
		else $error("default VLAN not set after reset");
	leave_dflt_a: assert property (reg_wr_i && reg_addr_i[9:8] == 2'h1 && // RULE9
		went != 8'h00 && 32'(went) < VLANS && reg_wdata_i[31] |=>
		(ent_mem_q[0] & $past(reg_wdata_i[`VTC_FIELD_LSB +: PORTS])) == '0)
		else $error("port left in default VLAN");
	strip_skip_a: assert property (st_q == ST_MAC && strip_q && emit && // RULE15
		rd_q == 5'd11 |=> st_q == ST_STRM)
		else $error("tag not stripped");
	ins_strip_a: assert property (!(ins_q && strip_q)) // RULE17
		else $error("insert and strip together");

	ins_path_c: cover property (st_q == ST_TAG ##[1:40] out_last_o);
	strip_path_c: cover property (st_q == ST_DEC && is_tag && !etag_q[eg_q]);
	drop_path_c: cover property (st_q == ST_DROP && in_last_i && take);

endmodule : vtc_classifier

`default_nettype wire

// *** vtc_defines.svh ***
// Constants for the VLAN tag classifier: tag values, header positions,
// reset values and register offsets.
// Assumes it is included by bare name by the classifier and checksum modules.
`ifndef VTC_DEFINES_SVH
`define VTC_DEFINES_SVH

// Tag protocol identifier and defaults.
`define VTC_TPID 16'h8100
`define VTC_DEF_VLAN 12'h001
`define VTC_DEF_PRIO 3'h0
`define VTC_CANON_INS 1'b0

// Header byte positions in the capture buffer.
`define VTC_HDR_LEN 5'd20
`define VTC_MAC_END 5'd11
`define VTC_TYPE_POS 5'd12
`define VTC_BODY_END 5'd15
`define VTC_TAG_END 5'd3

// Register word offsets and field positions.
`define VTC_REG_ETAG 10'h010
`define VTC_REG_PASS 10'h011
`define VTC_REG_DROP 10'h012
`define VTC_ENT_VALID_BIT 31
`define VTC_FIELD_LSB 12

// Ethernet frame check sequence polynomial and seed.
`define VTC_CRC_POLY 32'hEDB88320
`define VTC_CRC_SEED 32'hFFFFFFFF

`endif

// *** vtc_pkg.sv ***
// Types shared by the VLAN tag classifier modules.
// Assumes vtc_defines.svh is on the include path.
package vtc_pkg;

	typedef logic [11:0] vtc_vlan_id_t;

	// Capture, decide, then emit; the insert path steps one bit at a time up to ST_FCS.
	typedef enum logic [2:0] {
		ST_HDR = 3'h0,
		ST_DEC = 3'h1,
		ST_MAC = 3'h3,
		ST_TAG = 3'h2,
		ST_BODY = 3'h6,
		ST_STRM = 3'h7,
		ST_FCS = 3'h5,
		ST_DROP = 3'h4
	} vtc_state_t;

endpackage : vtc_pkg

// *** vtc_crc_if.sv ***
// Carrier between the frame rewriter and its checksum engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface vtc_crc_if;
	logic clr;
	logic en;
	logic [7:0] data;
	logic [31:0] crc;

	modport user (output clr, output en, output data, input crc);
	modport engine (input clr, input en, input data, output crc);
endinterface : vtc_crc_if

`default_nettype wire

// *** vtc_crc.sv ***
// Byte-wide Ethernet frame check sequence engine.
// Assumes bytes arrive in wire order, least significant bit first.
`include "vtc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module vtc_crc (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Checksum port.
	vtc_crc_if.engine crc_if
);
	import vtc_pkg::*;

	logic [31:0] crc_q;
	logic [31:0] crc_d;

	// Eight serial steps of the reflected polynomial per byte.
	always_comb begin
		crc_d = crc_q ^ {24'h000000, crc_if.data};
		for (int b = 0; b < 8; b++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ `VTC_CRC_POLY) : (crc_d >> 1);
		end
	end

	// The clear wins so that a fresh frame never inherits stale state.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || crc_if.clr) begin
			crc_q <= `VTC_CRC_SEED;
		end else if (crc_if.en) begin
			crc_q <= crc_d;
		end
	end

	assign crc_if.crc = crc_q;

endmodule : vtc_crc

`default_nettype wire

// *** vtc_sink.sv ***
// Egress partner: a tag-aware or tag-unaware station taking bytes.
// Assumes the classifier's egress byte stream on the same clock.
`timescale 1ns/1ps
`default_nettype none

module vtc_sink (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Egress stream and stall control.
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	input wire logic last_i,
	input wire logic slow_i,
	output logic ready_o
);
	logic [7:0] q[$];
	int frames;

	// A slow station stalls every other cycle, so held bytes get tested.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ready_o <= 1'b0;
			frames <= 0;
		end else begin
			if (valid_i && ready_o) begin
				q.push_back(data_i);
				frames <= frames + (last_i ? 1 : 0);
			end
			ready_o <= slow_i ? !ready_o : 1'b1;
		end
	end
endmodule : vtc_sink

`default_nettype wire

// *** tb_vlan_tag_classifier.sv ***
// Self-checking bench for the VLAN tag classifier.
// Assumes vtc_pkg, vtc_crc_if, vtc_crc, vtc_classifier, vtc_sink compiled.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) begin \
			n_fail++; \
			$display("wrong value %s exp %h got %h", nm, ex, got); \
		end \
	end

module tb_vlan_tag_classifier;
	typedef struct packed {
		logic tg;
		logic [15:0] tci;
		logic [3:0] eg;
		logic pass;
	} vtc_row_t;

	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [9:0] reg_addr_i = 10'h000;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic in_valid_i = 1'b0;
	logic [7:0] in_data_i = 8'h00;
	logic in_last_i = 1'b0;
	logic [3:0] in_port_i = 4'h2;
	logic [3:0] in_egress_port_i = 4'h0;
	logic in_ready_o;
	logic out_valid_o;
	logic [7:0] out_data_o;
	logic out_last_o;
	vtc_pkg::vtc_vlan_id_t out_vlan_id_o;
	logic [11:0] dflt_vlan = 12'h001;
	logic out_ready_i;
	logic slow = 1'b0;
	logic [15:0] etag = 16'h0;
	logic [31:0] d;
	logic [7:0] f[$];
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int n0;
	vtc_row_t rows[5] = '{'{1'b0, 16'h0000, 4'h3, 1'b1},
		'{1'b0, 16'h0000, 4'h5, 1'b1}, '{1'b1, 16'h6001, 4'h3, 1'b1},
		'{1'b1, 16'h6001, 4'h5, 1'b1}, '{1'b1, 16'h6007, 4'h3, 1'b0}};

	vtc_classifier #(.PORTS(10)) vtc_classifier_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
		.in_data_i(in_data_i), .in_last_i(in_last_i), .in_port_i(in_port_i),
		.in_egress_port_i(in_egress_port_i), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_data_o(out_data_o),
		.out_last_o(out_last_o), .out_vlan_id_o(out_vlan_id_o),
		.out_ready_i(out_ready_i));

	vtc_sink vtc_sink_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.valid_i(out_valid_o), .data_i(out_data_o), .last_i(out_last_o),
		.slow_i(slow), .ready_o(out_ready_i));

	// Clock of 100 ns period.
	always #50 clk_i = !clk_i;

	// Cuts a hang short; the tests need well under this many cycles.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	// Reflected Ethernet checksum over bytes in wire order.
	function automatic logic [31:0] crc(logic [7:0] b[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (b[i]) begin
			c = c ^ {24'h0, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
			end
		end
		return ~c;
	endfunction : crc

	// Broadcast frame body, optionally tagged, without checksum.
	function automatic void mk(ref logic [7:0] q[$], input logic tg,
		input logic [15:0] tci);
		q = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
			8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		if (tg) begin
			q = {q, 8'h81, 8'h00, tci[15:8], tci[7:0]};
		end
		q = {q, 8'h08, 8'h00};
		for (int k = 0; k < 30; k++) begin
			q.push_back(8'(k));
		end
	endfunction : mk

	// Checksum goes out least significant byte first.
	function automatic void addfcs(ref logic [7:0] q[$]);
		logic [31:0] c;
		c = crc(q);
		for (int k = 0; k < 4; k++) begin
			q.push_back(c[8*k +: 8]);
		end
	endfunction : addfcs

	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [9:0] a, output logic [31:0] v);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		v = reg_rdata_o;
	endtask : rd

	task automatic send(input logic [7:0] q[$], input logic [3:0] eg);
		foreach (q[i]) begin
			in_valid_i <= 1'b1;
			in_data_i <= q[i];
			in_last_i <= (i == q.size() - 1);
			in_egress_port_i <= eg;
			@(posedge clk_i);
			while (in_ready_o !== 1'b1) @(posedge clk_i);
		end
		in_valid_i <= 1'b0;
		in_last_i <= 1'b0;
	endtask : send

	// One frame from port 2; the expected egress is built from its config.
	task automatic run(input vtc_row_t r);
		logic [7:0] b[$];
		logic [7:0] e[$];
		logic [31:0] x;
		int w;
		mk(b, r.tg, r.tci);
		e = b;
		x = {16'h8100, 3'h5, 1'b0, dflt_vlan};
		if (etag[r.eg] && !r.tg) begin
			for (int k = 0; k < 4; k++) begin
				e.insert(12 + k, x[31-8*k -: 8]);
			end
		end
		if (!etag[r.eg] && r.tg) begin
			repeat (4) e.delete(12);
		end
		addfcs(b);
		addfcs(e);
		n0 = vtc_sink_inst.frames;
		vtc_sink_inst.q.delete();
		send(b, r.eg);
		w = 0;
		while (vtc_sink_inst.frames == n0 && w < 400) begin
			@(posedge clk_i);
			w++;
		end
		if (r.pass) begin
			`CHK("length", e.size(), vtc_sink_inst.q.size())
			foreach (e[i]) `CHK("byte", e[i], vtc_sink_inst.q[i])
			`CHK("vlan", r.tg ? r.tci[11:0] : dflt_vlan, out_vlan_id_o)
		end else begin
			`CHK("frames", n0, vtc_sink_inst.frames)
		end
	endtask : run

	task automatic final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// Main sequence: reset, table rows, then the awkward cases.
	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK("vlan_reset", 12'h001, out_vlan_id_o)
		rd(10'h000, d);
		`CHK("dflt_reset", 32'h1, d)
		rd(10'h010, d);
		`CHK("etag_reset", 32'h0, d)
		rd(10'h100, d);
		`CHK("entry0_reset", 32'h803FF001, d)
		rd(10'h3FF, d);
		`CHK("unmapped", 32'h0, d)
		wr(10'h002, 32'h00005001);
		wr(10'h010, 32'h00000020);
		etag = 16'h0020;
		rd(10'h010, d);
		`CHK("etag", 32'h20, d)
		foreach (rows[i]) begin
			run(rows[i]);
		end
		slow <= 1'b1;
		wr(10'h101, 32'h80060007);
		rd(10'h100, d);
		`CHK("entry0_left", 32'h8039F001, d)
		wr(10'h102, 32'h80020009);
		run(vtc_row_t'{1'b1, 16'h6007, 4'h5, 1'b1});
		run(vtc_row_t'{1'b1, 16'h2009, 4'h5, 1'b1});
		run(vtc_row_t'{1'b0, 16'h0000, 4'h5, 1'b0});
		run(vtc_row_t'{1'b1, 16'h2007, 4'h3, 1'b0});
		// A default id other than the reset value proves the port lookup.
		wr(10'h002, 32'h00005009);
		dflt_vlan = 12'h009;
		run(vtc_row_t'{1'b0, 16'h0000, 4'h5, 1'b1});
		// The last table entry is writable; one past it is not there.
		wr(10'h1FE, 32'h80000005);
		wr(10'h1FF, 32'h80000005);
		rd(10'h1FE, d);
		`CHK("last_entry", 32'h80000005, d)
		rd(10'h1FF, d);
		`CHK("past_table", 32'h0, d)
		mk(f, 1'b0, 16'h0);
		n0 = vtc_sink_inst.frames;
		send(f[0:15], 4'h3);
		repeat (100) @(posedge clk_i);
		`CHK("runt", n0, vtc_sink_inst.frames)
		rd(10'h011, d);
		`CHK("passed", 32'd7, d)
		rd(10'h012, d);
		`CHK("dropped", 32'd3, d)
		final_report();
	end
endmodule : tb_vlan_tag_classifier

`default_nettype wire
